// ==== src/prog_synth_frame_pulse_cfg.sv ====
// programmable synthesizer registers, clock generation and frame pulse shaping
// What this block does
// RULE_01: clock output at N times 8 kHz; N bits 13:8 from high multiplier bits 5:0.
// RULE_02: N bits 7:0 come from the low multiplier register.
// RULE_03: two-bit quadrant code shifts clock phase by 0, 90, 180 or 270 degrees.
// RULE_04: signed 8-bit fine delay, 119.2 ps steps, applies to clock and frame pulse.
// RULE_05: four-bit code selects frame rate from 166.67 Hz up to 64 kHz, or 1 Hz.
// RULE_06: style bit picks 50% clock (4 ms high at 1 Hz) or frame pulse.
// RULE_07: edge bit aligns pulse to rising or falling clock edge; 1 Hz uses rising.
// RULE_08: width code picks one period of 4.096..65.536 MHz, or one clock cycle.
// RULE_09: host must pick one-cycle width when clock is not an E1 multiple.
// RULE_10: polarity bit drives frame output positive or negative.
// RULE_11: 22-bit frame offset; low sixteen bits count 262.144 MHz periods.
// RULE_12: offset bits 7:0 from low byte register, bits 15:8 from mid byte.
// RULE_13: offset bits 21:16 from high byte register, in whole 8 kHz cycles.
// RULE_14: multi-byte values are applied together, never as a partial update.
`timescale 1ns/1ps
module prog_synth_frame_pulse_cfg
  import prog_synth_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic PROG_CLK_OUT,
  output logic FRAME_PULSE_OUT,
  output logic [7:0] FINE_DELAY_OUT
);
  typedef enum logic [1:0] {IDLE, ARMED, PULSE} frame_state_type;

  // staged register bytes, as seen by the host
  logic [7:0] mult_low_q;
  logic [5:0] mult_high_q;
  logic [1:0] quadrant_q;
  logic [7:0] fine_delay_q;
  logic [3:0] rate_sel_q;
  logic [7:0] shape_q;
  logic [7:0] ofs_low_q;
  logic [7:0] ofs_mid_q;
  logic [5:0] ofs_high_q;
  // committed multi-byte values used by the synthesizer
  logic [13:0] mult_act_q;
  logic [21:0] ofs_act_q;
  logic [31:0] nco_step_q;

  logic nco_clk;
  logic nco_rise;
  logic nco_fall;
  logic [25:0] frame_cnt_q;
  logic [25:0] frame_period;
  logic [19:0] ofs_cycles;
  logic frame_hit;
  logic sync_edge;
  frame_state_type state_q;
  logic [3:0] width_cnt_q;
  logic [3:0] width_cycles;
  logic style_level;
  logic raw_pulse;
  logic wr_sel;

  // frame period in system cycles for a rate code; unlisted codes fall back to 8 kHz
  function automatic logic [25:0] rate_period(input logic [3:0] code);
    case (code)
      4'h0: rate_period = 26'd300000;
      4'h1: rate_period = 26'd125000;
      4'h2: rate_period = 26'd50000;
      4'h3: rate_period = 26'd25000;
      4'h4: rate_period = 26'd12500;
      4'h5: rate_period = 26'd6250;
      4'h6: rate_period = 26'd1562;
      4'h7: rate_period = 26'd781;
      4'h8: rate_period = 26'(CLK_HZ);
      default: rate_period = 26'd6250;
    endcase
  endfunction : rate_period

  // pulse width in system cycles, rounded to at least one cycle
  function automatic logic [3:0] width_len(input logic [2:0] code);
    case (code)
      3'h0: width_len = 4'd12;
      3'h1: width_len = 4'd6;
      3'h2: width_len = 4'd3;
      3'h3: width_len = 4'd2;
      3'h4: width_len = 4'd1;
      default: width_len = 4'd1;
    endcase
  endfunction : width_len

  assign wr_sel = REG_WR_IN;

  // host writes; reserved bits are not stored
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mult_low_q <= RST_MULT_LOW;
      mult_high_q <= RST_MULT_HIGH;
      quadrant_q <= RST_QUADRANT;
      fine_delay_q <= RST_FINE_DELAY;
      rate_sel_q <= RST_RATE_SEL;
      shape_q <= RST_SHAPE & SHAPE_MASK;
      ofs_low_q <= RST_OFS_BYTE;
      ofs_mid_q <= RST_OFS_BYTE;
      ofs_high_q <= RST_OFS_HIGH;
    end else if (wr_sel) begin
      case (REG_ADDR_IN)
        ADDR_MULT_LOW: mult_low_q <= REG_WDATA_IN; // see RULE_02
        ADDR_MULT_HIGH: mult_high_q <= REG_WDATA_IN[5:0]; // see RULE_01
        ADDR_QUADRANT: quadrant_q <= REG_WDATA_IN[1:0];
        ADDR_FINE_DELAY: fine_delay_q <= REG_WDATA_IN;
        ADDR_RATE_SEL: rate_sel_q <= REG_WDATA_IN[3:0];
        ADDR_SHAPE: shape_q <= REG_WDATA_IN & SHAPE_MASK;
        ADDR_OFS_LOW: ofs_low_q <= REG_WDATA_IN;
        ADDR_OFS_MID: ofs_mid_q <= REG_WDATA_IN;
        ADDR_OFS_HIGH: ofs_high_q <= REG_WDATA_IN[5:0];
        default: ;
      endcase
    end
  end

  // writing the top byte commits the whole value, so partial updates never act
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mult_act_q <= {RST_MULT_HIGH, RST_MULT_LOW};
      ofs_act_q <= {RST_OFS_HIGH, RST_OFS_BYTE, RST_OFS_BYTE};
    end else begin
      if (wr_sel && REG_ADDR_IN == ADDR_MULT_HIGH) begin
        mult_act_q <= {REG_WDATA_IN[5:0], mult_low_q}; // see RULE_14 see RULE_01 see RULE_02
      end
      if (wr_sel && REG_ADDR_IN == ADDR_OFS_HIGH) begin
        ofs_act_q <= {REG_WDATA_IN[5:0], ofs_mid_q, ofs_low_q}; // see RULE_14 see RULE_12 see RULE_13
      end
    end
  end

  // registered read data; unmapped addresses and reserved bits read zero
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      case (REG_ADDR_IN)
        ADDR_MULT_LOW: REG_RDATA_OUT <= mult_low_q;
        ADDR_MULT_HIGH: REG_RDATA_OUT <= {2'h0, mult_high_q};
        ADDR_QUADRANT: REG_RDATA_OUT <= {6'h00, quadrant_q};
        ADDR_FINE_DELAY: REG_RDATA_OUT <= fine_delay_q;
        ADDR_RATE_SEL: REG_RDATA_OUT <= {4'h0, rate_sel_q};
        ADDR_SHAPE: REG_RDATA_OUT <= shape_q;
        ADDR_OFS_LOW: REG_RDATA_OUT <= ofs_low_q;
        ADDR_OFS_MID: REG_RDATA_OUT <= ofs_mid_q;
        ADDR_OFS_HIGH: REG_RDATA_OUT <= {2'h0, ofs_high_q};
        default: REG_RDATA_OUT <= 8'h00;
      endcase
    end
  end

  // nco step from committed N; registered to keep the multiply off the accumulator path
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      nco_step_q <= 32'h0000_0000;
    end else begin
      nco_step_q <= 32'((46'(mult_act_q) * 46'(NCO_STEP_X4096)) >> 12); // see RULE_01
    end
  end

  prog_nco u_nco (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .step_in(nco_step_q),
    .quadrant_in(quadrant_q),
    .clk_out(nco_clk),
    .rise_out(nco_rise),
    .fall_out(nco_fall)
  );

  // the sub-cycle delay goes to the output delay line on both pins
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FINE_DELAY_OUT <= RST_FINE_DELAY;
    end else begin
      FINE_DELAY_OUT <= fine_delay_q; // see RULE_04
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PROG_CLK_OUT <= 1'b0;
    end else begin
      PROG_CLK_OUT <= nco_clk;
    end
  end

  // frame timebase and offset; coarse in 8 kHz cycles, fine in 262.144 MHz periods
  assign frame_period = rate_period(rate_sel_q); // see RULE_05
  // widen before the multiply: 63 whole 8 kHz cycles need 19 bits
  assign ofs_cycles = (20'(ofs_act_q[21:16]) * 20'(CYC_PER_8K))
                    + 20'((28'(ofs_act_q[15:0]) * 28'(FINE_OFS_MUL)) >> FINE_OFS_SHIFT); // see RULE_11 see RULE_13
  // an offset beyond the frame period never matches, so no pulse is produced
  assign frame_hit = (frame_cnt_q == 26'(ofs_cycles));

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frame_cnt_q <= 26'h000_0000;
    end else if (frame_cnt_q >= frame_period - 26'd1) begin
      frame_cnt_q <= 26'h000_0000;
    end else begin
      frame_cnt_q <= frame_cnt_q + 26'd1;
    end
  end

  // falling edge is not offered at 1 Hz
  assign sync_edge = (shape_q[SHAPE_EDGE_BIT] && rate_sel_q != RATE_1HZ) ? nco_fall : nco_rise; // see RULE_07
  assign width_cycles = width_len(shape_q[SHAPE_WIDTH_LSB +: 3]); // see RULE_08

  // frame pulse sequencer: arm at offset, start on the chosen edge, hold for the width
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= IDLE;
      width_cnt_q <= 4'h0;
    end else begin
      case (state_q)
        IDLE: begin
          if (frame_hit) begin
            state_q <= ARMED;
          end
        end
        ARMED: begin
          if (sync_edge) begin
            state_q <= PULSE; // see RULE_07
            width_cnt_q <= width_cycles;
          end
        end
        PULSE: begin
          if (shape_q[SHAPE_WIDTH_LSB +: 3] == WIDTH_ONE_CYCLE) begin
            if (sync_edge) begin
              state_q <= IDLE; // see RULE_08
            end
          end else if (width_cnt_q <= 4'd1) begin
            state_q <= IDLE; // see RULE_08
          end else begin
            width_cnt_q <= width_cnt_q - 4'd1;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end

  // clock style: high for half the frame, or 4 ms at 1 Hz
  assign style_level = (rate_sel_q == RATE_1HZ) ? (frame_cnt_q < ONE_HZ_HIGH_CYC)
                                                : (frame_cnt_q < (frame_period >> 1)); // see RULE_06
  assign raw_pulse = shape_q[SHAPE_STYLE_BIT] ? (state_q == PULSE) : style_level; // see RULE_06

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      FRAME_PULSE_OUT <= 1'b0;
    end else begin
      FRAME_PULSE_OUT <= raw_pulse ^ shape_q[SHAPE_POL_BIT]; // see RULE_10
    end
  end
endmodule : prog_synth_frame_pulse_cfg

// ==== src/prog_synth_pkg.sv ====
// constants for the programmable clock and frame pulse synthesizer
package prog_synth_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_MULT_LOW = 8'h38;
  localparam logic [7:0] ADDR_MULT_HIGH = 8'h39;
  localparam logic [7:0] ADDR_QUADRANT = 8'h3a;
  localparam logic [7:0] ADDR_FINE_DELAY = 8'h3d;
  localparam logic [7:0] ADDR_RATE_SEL = 8'h3e;
  localparam logic [7:0] ADDR_SHAPE = 8'h3f;
  localparam logic [7:0] ADDR_OFS_LOW = 8'h40;
  localparam logic [7:0] ADDR_OFS_MID = 8'h41;
  localparam logic [7:0] ADDR_OFS_HIGH = 8'h42;
  // values after reset
  localparam logic [7:0] RST_MULT_LOW = 8'h00;
  localparam logic [5:0] RST_MULT_HIGH = 6'h01;
  localparam logic [1:0] RST_QUADRANT = 2'h0;
  localparam logic [7:0] RST_FINE_DELAY = 8'h00;
  localparam logic [3:0] RST_RATE_SEL = 4'h5;
  localparam logic [7:0] RST_SHAPE = 8'h83;
  localparam logic [7:0] RST_OFS_BYTE = 8'h00;
  localparam logic [5:0] RST_OFS_HIGH = 6'h00;
  // shape register field positions
  localparam int SHAPE_STYLE_BIT = 0;
  localparam int SHAPE_EDGE_BIT = 1;
  localparam int SHAPE_WIDTH_LSB = 4;
  localparam int SHAPE_POL_BIT = 7;
  localparam logic [7:0] SHAPE_MASK = 8'hf3;
  // timing, system clock 50 MHz
  localparam longint CLK_HZ = 50_000_000;
  localparam real ONE_HZ_HIGH_MS = 4.0;
  localparam logic [25:0] ONE_HZ_HIGH_CYC = 26'(int'(ONE_HZ_HIGH_MS * real'(CLK_HZ) / 1000.0));
  localparam logic [12:0] CYC_PER_8K = 13'(CLK_HZ / 8000);
  // nco increment per unit of N: 8 kHz * 2^32 / clk, scaled by 2^12
  localparam logic [31:0] NCO_STEP_X4096 = 32'ha7c5_ac47;
  // fine offset unit is 1/262.144 MHz = 3125/16384 system cycles
  localparam logic [11:0] FINE_OFS_MUL = 12'hc35;
  localparam int FINE_OFS_SHIFT = 14;
  // rate and width codes
  localparam logic [3:0] RATE_1HZ = 4'h8;
  localparam logic [2:0] WIDTH_ONE_CYCLE = 3'h7;
endpackage : prog_synth_pkg

// ==== src/prog_nco.sv ====
// phase accumulator that makes the programmable clock with quadrant shift
`timescale 1ns/1ps
module prog_nco
  import prog_synth_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [31:0] step_in,
  input wire logic [1:0] quadrant_in,
  output logic clk_out,
  output logic rise_out,
  output logic fall_out
);
  logic [31:0] acc_q;
  logic [31:0] phase;
  logic prev_q;

  // accumulator; frequency is step * 50 MHz / 2^32, so jitter is one system cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= 32'h0000_0000;
    end else begin
      acc_q <= acc_q + step_in;
    end
  end

  // quadrant adds a quarter turn per code step
  assign phase = acc_q + {quadrant_in, 30'h0000_0000}; // see RULE_03

  // registered clock level and edge strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_out <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      clk_out <= phase[31];
      prev_q <= clk_out;
    end
  end

  assign rise_out = clk_out & ~prev_q;
  assign fall_out = ~clk_out & prev_q;
endmodule : prog_nco

// ==== tb/psf_asserts.sv ====
// port checker for the programmable synthesizer
`timescale 1ns/1ps
module psf_asserts
  import prog_synth_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic PROG_CLK_OUT,
  input wire logic FRAME_PULSE_OUT,
  input wire logic [7:0] FINE_DELAY_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [7:0] shape_q, fine_q;
  logic [2:0] age_q;
  wire logic fwr = REG_WR_IN && REG_ADDR_IN == ADDR_FINE_DELAY;
  wire logic swr = REG_WR_IN && REG_ADDR_IN == ADDR_SHAPE;
  wire logic act = FRAME_PULSE_OUT ^ shape_q[SHAPE_POL_BIT];
  wire logic frm = age_q == 3'h7 && shape_q[SHAPE_STYLE_BIT];
  // reserved bits per address; unmapped places read all zero
  function automatic logic [7:0] rsv(input logic [7:0] a);
    case (a)
      ADDR_MULT_LOW, ADDR_FINE_DELAY, ADDR_OFS_LOW, ADDR_OFS_MID: return 8'h00;
      ADDR_MULT_HIGH, ADDR_OFS_HIGH: return 8'hc0;
      ADDR_QUADRANT: return 8'hfc;
      ADDR_RATE_SEL: return 8'hf0;
      ADDR_SHAPE: return 8'h0c;
      default: return 8'hff;
    endcase
  endfunction : rsv
  // shadows; age gives the registered outputs time to follow a shape change
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      shape_q <= RST_SHAPE;
      fine_q <= RST_FINE_DELAY;
      age_q <= 3'h0;
    end else begin
      if (swr) shape_q <= REG_WDATA_IN;
      if (fwr) fine_q <= REG_WDATA_IN;
      age_q <= swr ? 3'h0 : (age_q == 3'h7 ? 3'h7 : age_q + 3'h1);
    end
  end
  property p_rdback; fwr ##1 REG_ADDR_IN == ADDR_FINE_DELAY && !REG_WR_IN |=> REG_RDATA_OUT == fine_q; endproperty
  a_rdback: assert property (p_rdback) else $error("fine delay reads back wrong");
  property p_fine; !fwr && !$past(fwr) |-> FINE_DELAY_OUT == fine_q; endproperty
  a_fine: assert property (p_fine) else $error("fine delay output stale");
  property p_rsv; (REG_RDATA_OUT & rsv($past(REG_ADDR_IN))) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved or unmapped bits read nonzero");
  property p_shape; $past(REG_ADDR_IN) == ADDR_SHAPE && age_q != 3'h0 |-> REG_RDATA_OUT == (shape_q & SHAPE_MASK); endproperty
  a_shape: assert property (p_shape) else $error("shape register reads back wrong");
  property p_w1; frm && shape_q[6:4] == 3'h4 && $rose(act) |=> !act; endproperty
  a_w1: assert property (p_w1) else $error("shortest pulse not one cycle");
  property p_w3; frm && shape_q[6:4] == 3'h2 && $rose(act) |-> act [*3] ##1 !act; endproperty
  a_w3: assert property (p_w3) else $error("pulse width code two wrong");
  property p_w6; frm && shape_q[6:4] == 3'h1 && $rose(act) |-> act [*6] ##1 !act; endproperty
  a_w6: assert property (p_w6) else $error("pulse width code one wrong");
  property p_half; age_q == 3'h7 && !shape_q[SHAPE_STYLE_BIT] && $rose(act) |-> act [*8]; endproperty
  a_half: assert property (p_half) else $error("clock style high phase too short");
  c_pulse: cover property (frm && $rose(act));
  c_unmapped: cover property (rsv(REG_ADDR_IN) == 8'hff);
  c_clk: cover property ($rose(PROG_CLK_OUT));
endmodule : psf_asserts
bind prog_synth_frame_pulse_cfg psf_asserts u_psf_asserts (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .PROG_CLK_OUT(PROG_CLK_OUT), .FRAME_PULSE_OUT(FRAME_PULSE_OUT), .FINE_DELAY_OUT(FINE_DELAY_OUT));

// ==== tb/test_prog_synth_frame_pulse_cfg.sv ====
// self-checking bench for the programmable synthesizer
`timescale 1ns/1ps
module test_prog_synth_frame_pulse_cfg
  import prog_synth_pkg::*;
;
  logic CLOCK_IN, RST_N_IN, REG_WR_IN, pol, lvl;
  logic [7:0] REG_ADDR_IN, REG_WDATA_IN, d, e;
  wire logic [7:0] REG_RDATA_OUT, FINE_DELAY_OUT;
  wire logic PROG_CLK_OUT, FRAME_PULSE_OUT;
  int n_mismatch, checked, seed, cyc, i, k, w, t0, t1;
  logic [7:0] ad[10] = '{8'h38, 8'h39, 8'h3a, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h3b};
  logic [7:0] rv[10] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h05, 8'h83, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mk[10] = '{8'hff, 8'h3f, 8'h03, 8'hff, 8'h0f, 8'hf3, 8'hff, 8'hff, 8'h3f, 8'h00};
  int wid[6] = '{12, 6, 3, 2, 1, 1};
  int fr[3] = '{8000, 32000, 64000};
  prog_synth_frame_pulse_cfg u_prog_synth_frame_pulse_cfg (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .PROG_CLK_OUT(PROG_CLK_OUT), .FRAME_PULSE_OUT(FRAME_PULSE_OUT), .FINE_DELAY_OUT(FINE_DELAY_OUT));
  // 50 MHz clock and a cycle count for pulse timing
  initial begin
    CLOCK_IN = 1'b0;
    forever #10 CLOCK_IN = ~CLOCK_IN;
  end
  always @(posedge CLOCK_IN) cyc <= cyc + 1;
  function automatic int dif(input int x);
    return ((x % 781) + 781) % 781;
  endfunction : dif
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : cmp
  // measured times jitter by one synthesizer period, so they get a tolerance
  task automatic near(input string nm, input int ex, input int got, input int tol);
    checked++;
    if (got < ex - tol || got > ex + tol) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : near
  task automatic tick;
    @(posedge CLOCK_IN);
    #1;
  endtask : tick
  // strobe is dropped a full cycle before the next write may raise it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    REG_ADDR_IN = a;
    REG_WDATA_IN = v;
    REG_WR_IN = 1'b1;
    tick;
    REG_WR_IN = 1'b0;
    tick;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    REG_ADDR_IN = a;
    tick;
    v = REG_RDATA_OUT;
  endtask : rd
  task automatic edges(output int n);
    logic p;
    n = 0;
    repeat (6250) begin
      p = PROG_CLK_OUT;
      tick;
      n += int'(PROG_CLK_OUT && !p);
    end
  endtask : edges
  // next active pulse: start cycle, length, clock level at its start
  task automatic pulse(input int lim, output int st, output int wd, output logic ck);
    int n;
    for (n = 0; (FRAME_PULSE_OUT ^ pol) !== 1'b0 && n < lim; n++) tick;
    for (; (FRAME_PULSE_OUT ^ pol) !== 1'b1 && n < lim; n++) tick;
    st = cyc;
    ck = PROG_CLK_OUT;
    for (wd = 0; (FRAME_PULSE_OUT ^ pol) === 1'b1 && wd < lim; wd++) tick;
    if (n >= lim || wd >= lim) begin
      n_mismatch++;
      $display("MISMATCH pulse expected edge seen none");
      wrap_up;
    end
  endtask : pulse
  initial begin
    seed = 32'h25f6_84cb;
    RST_N_IN = 1'b0;
    REG_WR_IN = 1'b0;
    REG_ADDR_IN = 8'h00;
    REG_WDATA_IN = 8'h00;
    pol = 1'b0;
    repeat (4) @(posedge CLOCK_IN);
    #1 RST_N_IN = 1'b1;
    for (i = 0; i < 10; i++) begin
      rd(ad[i], d);
      cmp("reset", rv[i], d);
    end
    // random bytes read back without reserved bits
    for (i = 0; i < 20; i++) begin
      e = 8'($random(seed));
      wr(ad[i % 10], e);
      rd(ad[i % 10], d);
      cmp("readback", e & mk[i % 10], d);
      if (ad[i % 10] == 8'h3d) cmp("fine", e, FINE_DELAY_OUT);
    end
    wr(8'h38, 8'h00);
    wr(8'h39, 8'h01);
    wr(8'h3a, 8'h02);
    edges(k);
    near("n256", 256, k, 1);
    wr(8'h38, 8'h80);
    edges(k);
    near("staged", 256, k, 1);
    wr(8'h39, 8'h02);
    edges(k);
    near("n640", 640, k, 1);
    // n = 256 gives 2.048 MHz, an e1 multiple, so the preset widths below are legal
    wr(8'h38, 8'h00);
    wr(8'h39, 8'h01);
    wr(8'h40, 8'h00);
    wr(8'h41, 8'h00);
    wr(8'h42, 8'h00);
    wr(8'h3f, 8'h41);
    for (i = 5; i < 8; i++) begin
      wr(8'h3e, 8'(i));
      pulse(7000, t0, w, lvl);
      pulse(7000, t1, w, lvl);
      near("period", 50_000_000 / fr[i - 5], t1 - t0, 30);
    end
    for (i = 0; i < 6; i++) begin
      wr(8'h3f, {1'b0, i[2:0], 4'h1});
      pulse(2000, t0, w, lvl);
      pulse(2000, t0, w, lvl);
      cmp("width", wid[i], w);
      cmp("rise_sync", 1'b1, lvl);
    end
    wr(8'h3f, 8'h71);
    pulse(2000, t0, w, lvl);
    near("cyc_width", 50_000_000 / 2_048_000, w, 2);
    wr(8'h3f, 8'h73);
    pulse(2000, t0, w, lvl);
    pulse(2000, t0, w, lvl);
    cmp("fall_sync", 1'b0, lvl);
    pol = 1'b1;
    wr(8'h3f, 8'hc1);
    pulse(2000, t0, w, lvl);
    pulse(2000, t0, w, lvl);
    cmp("neg_width", 1, w);
    pol = 1'b0;
    wr(8'h3e, 8'h05);
    wr(8'h3f, 8'h00);
    pulse(14000, t0, w, lvl);
    pulse(14000, t0, w, lvl);
    cmp("half", 50_000_000 / 8000 / 2, w);
    // offset shifts the pulse only once the top byte commits
    wr(8'h3e, 8'h07);
    wr(8'h3f, 8'h41);
    pulse(2000, t0, w, lvl);
    pulse(2000, t0, w, lvl);
    wr(8'h40, 8'h40);
    wr(8'h41, 8'h08);
    pulse(2000, t1, w, lvl);
    near("ofs_staged", 390, dif(t1 - t0 + 390), 30);
    wr(8'h42, 8'h00);
    pulse(2000, t1, w, lvl);
    pulse(2000, t1, w, lvl);
    near("ofs", (16'h0840 * 3125) >> 14, dif(t1 - t0), 30);
    wr(8'h42, 8'h01);
    repeat (800) tick;
    k = 0;
    repeat (1600) begin
      tick;
      k += int'(FRAME_PULSE_OUT !== 1'b0);
    end
    cmp("no_pulse", 0, k);
    wrap_up;
  end
endmodule : test_prog_synth_frame_pulse_cfg
